// ==== verilog/asp_defs.svh ====
/*
  Register offsets, field positions, reset values and timing counts of the
  asynchronous serial port. Assumes an 8-bit AXI4-Lite byte address.
*/
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ASP_TXS_OFS   8'h00
`define ASP_RCS_OFS   8'h04
`define ASP_BDC_OFS   8'h08
`define ASP_DLO_OFS   8'h0c
`define ASP_DHI_OFS   8'h10
`define ASP_TXB_OFS   8'h14
`define ASP_RXB_OFS   8'h18
`define ASP_IEN_OFS   8'h1c
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TXS_NINE      6
`define TXS_ENABLE    5
`define TXS_SYNC      4
`define TXS_HIGH      2
`define TXS_EMPTY     1
`define TXS_D9        0
`define RCS_PORT      7
`define RCS_RX9       6
`define RCS_RX_ON     4
`define RCS_FERR      2
`define RCS_OERR      1
`define RCS_D9        0
`define BDC_POL       4
`define BDC_WIDE      3
`define IEN_GLOBAL    0
`define IEN_PERIPH    1
`define IEN_TX_INT    2
`define IEN_RXIE      3
`define IEN_TXF       4
`define IEN_RXF       5
// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define ASP_REG_RST   8'h00
`define ASP_OVERSAMPLE 16
`define ASP_FRAME8    4'ha
`endif

// ==== verilog/asp_pkg.sv ====
/*
  Types of the asynchronous serial port: control groups, receive entries
  and receiver states. Assumes asp_defs.svh holds the numbers.
*/
`default_nettype none
package asp_pkg;
  typedef struct packed {
    logic nine;
    logic enable;
    logic sync;
    logic high;
    logic d9;
  } txs_t;
  typedef struct packed {
    logic port_en;
    logic rx9;
    logic rx_en;
  } rcs_t;
  typedef struct packed {
    logic pol;
    logic wide;
  } bdc_t;
  typedef struct packed {
    logic rxie;
    logic tx_int;
    logic periph_en;
    logic global_en;
  } ien_t;
  typedef struct packed {
    logic       ferr;
    logic [8:0] data;
  } rx_char_t;
  typedef enum logic [1:0] {
    R_IDLE  = 2'b00,
    R_START = 2'b01,
    R_DATA  = 2'b11,
    R_STOP  = 2'b10
  } rx_state_t;
endpackage
`default_nettype wire

// ==== verilog/async_serial_port.sv ====
/*
  Asynchronous serial port: transmit holding buffer and shifter, receive
  front end with a two-entry queue, AXI4-Lite register slave.
  Assumes one clock aclk, synchronous active-low aresetn, an asynchronous
  receive pin and an external pad resolving the transmit pin from its enable.
*/
// What this block does
// - Transmit needs enable, async mode, port on
// - Port enable makes transmit pin output
// - Write to idle shifter loads at once
// - Busy shifter: reload one cycle after stop
// - Frame starts right after shifter load
// - Polarity select inverts async line output
// - Empty flag set while transmit on and no character queued
// - Empty flag valid second cycle after write
// - Empty flag read-only, hardware driven only
// - Flag independent of interrupt enable
// - Interrupt when flag and all enables
// - Shifter status empty until load, shifts
// - Nine-bit select shifts ninth bit too
// - Ninth bit written first, loaded together
// - Receiver samples at OVERSAMPLE times baud, default sixteen
// - Completed character enters two-entry queue unless full, which sets overrun
// - Received data read via buffer, ninth bit via receive status
// - Receive needs enable, async mode, port on
// - Start space, data, stop mark, idle mark
// - LSB first, shared rate; receive has its own nine-bit select (rx9) and no polarity inversion
// - Pending flag set while receive on and characters unread
`timescale 1ns/1ps
`include "asp_defs.svh"
`default_nettype none
module async_serial_port import asp_pkg::*; #(
  parameter int OVERSAMPLE = `ASP_OVERSAMPLE
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        receive_data_pin,
  output logic             transmit_clock_pin_out,
  output logic             transmit_clock_pin_oe_n,
  output logic             transmit_irq,
  output logic             receive_irq
);
  // --------------------------------------------------------------------
  // Parameter check
  // --------------------------------------------------------------------
  if (OVERSAMPLE < 4 || OVERSAMPLE > 16) begin : g_chk
    $error("OVERSAMPLE must lie in 4..16");
  end
  localparam logic [3:0] OS_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] OS_HALF = 4'(OVERSAMPLE / 2 - 1);

  txs_t        txs, next_txs;
  rcs_t        rcs, next_rcs;
  bdc_t        bdc, next_bdc;
  ien_t        ien, next_ien;
  logic [7:0]  div_lo, next_div_lo;
  logic [7:0]  div_hi, next_div_hi;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        hold_full, next_hold_full;
  logic [8:0]  hold_data, next_hold_data;
  logic        sh_busy, next_sh_busy;
  logic [10:0] sh_reg, next_sh_reg;
  logic [3:0]  sh_cnt, next_sh_cnt;
  logic [3:0]  tx_os, next_tx_os;
  logic        tx_flag, next_tx_flag;
  logic        next_pin;
  logic [15:0] brg_cnt, next_brg_cnt;
  logic        rx_m1, rx_m2, rx_m3, rx_f, next_rx_f;
  rx_state_t   rx_state, next_rx_state;
  logic [3:0]  rx_os, next_rx_os;
  logic [3:0]  rx_bits, next_rx_bits;
  logic [8:0]  rx_shift, next_rx_shift;
  rx_char_t    fifo [2];
  rx_char_t    next_fifo [2];
  logic        rd_ptr, next_rd_ptr;
  logic [1:0]  fifo_cnt, next_fifo_cnt;
  logic        oerr, next_oerr;

  logic        wr_go, rd_go, wr_lane0, tx_write, rx_pop;
  logic        port_on, tx_on, rx_on, tick16, tx_bit_end, rx_flag;
  logic        rx_push;
  logic [15:0] div_sel;
  rx_char_t    top;

  // --------------------------------------------------------------------
  // Bus handshakes and enables
  // --------------------------------------------------------------------
  assign wr_go    = awvalid & wvalid & ~bvalid;
  assign awready  = wr_go;
  assign wready   = wr_go;
  assign rd_go    = arvalid & ~rvalid;
  assign arready  = rd_go;
  assign wr_lane0 = wr_go & wstrb[0];
  assign tx_write = wr_lane0 & (awaddr == `ASP_TXB_OFS);
  assign rx_pop   = rd_go & (araddr == `ASP_RXB_OFS) & (fifo_cnt != 2'd0);
  assign port_on  = rcs.port_en;
  assign tx_on    = rcs.port_en & ~txs.sync & txs.enable;
  assign rx_on    = rcs.port_en & ~txs.sync & rcs.rx_en;
  assign top      = fifo[rd_ptr];
  assign rx_flag  = rx_on & (fifo_cnt != 2'd0);
  assign transmit_clock_pin_oe_n = ~rcs.port_en;
  assign transmit_irq = tx_flag & ien.tx_int & ien.periph_en & ien.global_en;
  assign receive_irq  = rx_flag & ien.rxie & ien.periph_en & ien.global_en;

  // --------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------
  always_comb begin
    next_txs    = txs;
    next_rcs    = rcs;
    next_bdc    = bdc;
    next_ien    = ien;
    next_div_lo = div_lo;
    next_div_hi = div_hi;
    next_bvalid = bvalid & ~bready;
    next_bresp  = bresp;
    next_rvalid = rvalid & ~rready;
    next_rresp  = rresp;
    next_rdata  = rdata;
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_bresp  = 2'b00;
      case (awaddr)
        `ASP_TXS_OFS: if (wstrb[0]) begin
          next_txs.nine = wdata[`TXS_NINE];
          next_txs.enable = wdata[`TXS_ENABLE];
          next_txs.sync = wdata[`TXS_SYNC];
          next_txs.high = wdata[`TXS_HIGH];
          next_txs.d9   = wdata[`TXS_D9];
        end
        `ASP_RCS_OFS: if (wstrb[0]) begin
          next_rcs.port_en = wdata[`RCS_PORT];
          next_rcs.rx9     = wdata[`RCS_RX9];
          next_rcs.rx_en   = wdata[`RCS_RX_ON];
        end
        `ASP_BDC_OFS: if (wstrb[0]) begin
          next_bdc.pol  = wdata[`BDC_POL];
          next_bdc.wide = wdata[`BDC_WIDE];
        end
        `ASP_DLO_OFS: if (wstrb[0]) begin
          next_div_lo = wdata[7:0];
        end
        `ASP_DHI_OFS: if (wstrb[0]) begin
          next_div_hi = wdata[7:0];
        end
        `ASP_IEN_OFS: if (wstrb[0]) begin
          next_ien.global_en = wdata[`IEN_GLOBAL];
          next_ien.periph_en = wdata[`IEN_PERIPH];
          next_ien.tx_int    = wdata[`IEN_TX_INT];
          next_ien.rxie = wdata[`IEN_RXIE];
        end
        `ASP_TXB_OFS: next_bresp = 2'b00;
        default:      next_bresp = 2'b10;
      endcase
    end
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp  = 2'b00;
      next_rdata  = 32'h0000_0000;
      case (araddr)
        `ASP_TXS_OFS: begin
          next_rdata[`TXS_NINE]  = txs.nine;
          next_rdata[`TXS_ENABLE] = txs.enable;
          next_rdata[`TXS_SYNC]  = txs.sync;
          next_rdata[`TXS_HIGH]  = txs.high;
          next_rdata[`TXS_EMPTY] = ~sh_busy;
          next_rdata[`TXS_D9]    = txs.d9;
        end
        `ASP_RCS_OFS: begin
          next_rdata[`RCS_PORT]  = rcs.port_en;
          next_rdata[`RCS_RX9]   = rcs.rx9;
          next_rdata[`RCS_RX_ON] = rcs.rx_en;
          next_rdata[`RCS_FERR] = top.ferr & (fifo_cnt != 2'd0);
          next_rdata[`RCS_OERR] = oerr;
          next_rdata[`RCS_D9]   = top.data[8];
        end
        `ASP_BDC_OFS: begin
          next_rdata[`BDC_POL]  = bdc.pol;
          next_rdata[`BDC_WIDE] = bdc.wide;
        end
        `ASP_DLO_OFS: next_rdata[7:0] = div_lo;
        `ASP_DHI_OFS: next_rdata[7:0] = div_hi;
        `ASP_TXB_OFS: next_rdata[7:0] = 8'h00;
        `ASP_RXB_OFS: next_rdata[7:0] = top.data[7:0];
        `ASP_IEN_OFS: begin
          next_rdata[3:0]       = ien;
          next_rdata[`IEN_TXF]  = tx_flag;
          next_rdata[`IEN_RXF]  = rx_flag;
        end
        default: next_rresp = 2'b10;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txs    <= '0;
      rcs    <= '0;
      bdc    <= '0;
      ien    <= '0;
      div_lo <= `ASP_REG_RST;
      div_hi <= `ASP_REG_RST;
      bvalid <= 1'b0;
      bresp  <= 2'b00;
      rvalid <= 1'b0;
      rresp  <= 2'b00;
      rdata  <= 32'h0000_0000;
    end else begin
      txs    <= next_txs;
      rcs    <= next_rcs;
      bdc    <= next_bdc;
      ien    <= next_ien;
      div_lo <= next_div_lo;
      div_hi <= next_div_hi;
      bvalid <= next_bvalid;
      bresp  <= next_bresp;
      rvalid <= next_rvalid;
      rresp  <= next_rresp;
      rdata  <= next_rdata;
    end
  end

  // --------------------------------------------------------------------
  // Oversampling tick
  // --------------------------------------------------------------------
  assign div_sel = bdc.wide ? {div_hi, div_lo} : {8'h00, div_lo};
  assign tick16  = port_on & (brg_cnt == div_sel);
  always_comb begin
    next_brg_cnt = brg_cnt + 16'h0001;
    if (!port_on || tick16) begin
      next_brg_cnt = 16'h0000;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brg_cnt <= 16'h0000;
    end else begin
      brg_cnt <= next_brg_cnt;
    end
  end

  // --------------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------------
  // one bit per bit tick
  assign tx_bit_end = tick16 & (tx_os == OS_LAST);
  always_comb begin
    next_hold_full = hold_full;
    next_hold_data = hold_data;
    next_sh_busy   = sh_busy;
    next_sh_reg    = sh_reg;
    next_sh_cnt    = sh_cnt;
    next_tx_os     = tick16 ? tx_os + 4'h1 : tx_os;
    if (tx_bit_end) begin
      next_tx_os = 4'h0;
    end
    if (sh_busy && tx_bit_end) begin
      next_sh_reg = {1'b1, sh_reg[10:1]};
      next_sh_cnt = sh_cnt - 4'h1;
      if (sh_cnt == 4'h1) begin
        next_sh_busy = 1'b0;
      end
    end
    if (!sh_busy && (hold_full || tx_write)) begin
      next_sh_busy   = 1'b1;
      next_tx_os     = 4'h0;
      next_hold_full = hold_full & tx_write;
      next_hold_data = {txs.d9, wdata[7:0]};
      if (hold_full) begin
        next_sh_reg = {1'b1, txs.nine ? hold_data[8] : 1'b1, hold_data[7:0], 1'b0};
      end else begin
        next_sh_reg = {1'b1, txs.nine ? txs.d9 : 1'b1, wdata[7:0], 1'b0};
      end
      next_sh_cnt = txs.nine ? 4'hb : 4'ha;
    end else if (tx_write) begin
      next_hold_full = 1'b1;
      next_hold_data = {txs.d9, wdata[7:0]};
    end
    if (!tx_on) begin
      next_hold_full = 1'b0;
      next_sh_busy   = 1'b0;
      next_sh_reg    = 11'h7ff;
      next_sh_cnt    = 4'h0;
      next_tx_os     = 4'h0;
    end
    next_tx_flag = tx_on & ~hold_full;
    // start bit drives out on the cycle after load
    next_pin = (sh_busy ? sh_reg[0] : 1'b1) ^ (bdc.pol & ~txs.sync);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_full <= 1'b0;
      hold_data <= 9'h000;
      sh_busy   <= 1'b0;
      sh_reg    <= 11'h7ff;
      sh_cnt    <= 4'h0;
      tx_os     <= 4'h0;
      tx_flag   <= 1'b0;
      transmit_clock_pin_out <= 1'b1;
    end else begin
      hold_full <= next_hold_full;
      hold_data <= next_hold_data;
      sh_busy   <= next_sh_busy;
      sh_reg    <= next_sh_reg;
      sh_cnt    <= next_sh_cnt;
      tx_os     <= next_tx_os;
      tx_flag   <= next_tx_flag;
      transmit_clock_pin_out <= next_pin;
    end
  end

  // --------------------------------------------------------------------
  // Receiver front end and queue
  // --------------------------------------------------------------------
  assign rx_push = (rx_state == R_STOP) & tick16 & (rx_os == OS_LAST);
  always_comb begin
    next_rx_f     = (rx_m2 == rx_m3) ? rx_m3 : rx_f;
    next_rx_state = rx_state;
    next_rx_os    = tick16 ? rx_os + 4'h1 : rx_os;
    next_rx_bits  = rx_bits;
    next_rx_shift = rx_shift;
    next_fifo     = fifo;
    next_rd_ptr   = rd_ptr;
    next_fifo_cnt = fifo_cnt;
    next_oerr     = oerr & rcs.rx_en;
    if (rx_pop) begin
      next_rd_ptr   = ~rd_ptr;
      next_fifo_cnt = fifo_cnt - 2'd1;
    end
    case (rx_state)
      R_IDLE: begin
        next_rx_os = 4'h0;
        if (!rx_f && !oerr) begin
          next_rx_state = R_START;
        end
      end
      R_START: if (tick16 && rx_os == OS_HALF) begin
        next_rx_os    = 4'h0;
        next_rx_bits  = 4'h0;
        next_rx_state = rx_f ? R_IDLE : R_DATA;
      end
      R_DATA: if (tick16 && rx_os == OS_LAST) begin
        next_rx_os    = 4'h0;
        next_rx_shift = {rx_f, rx_shift[8:1]};
        next_rx_bits  = rx_bits + 4'h1;
        if (rx_bits == (rcs.rx9 ? 4'h8 : 4'h7)) begin
          next_rx_state = R_STOP;
        end
      end
      R_STOP: if (rx_push) begin
        next_rx_state = R_IDLE;
        if (next_fifo_cnt == 2'd2) begin
          next_oerr = 1'b1;
        end else begin
          // Index after any pop in this cycle, so a pop never loses the newest entry
          next_fifo[next_rd_ptr ^ next_fifo_cnt[0]].ferr = ~rx_f;
          next_fifo[next_rd_ptr ^ next_fifo_cnt[0]].data =
            rcs.rx9 ? rx_shift : {1'b0, rx_shift[8:1]};
          next_fifo_cnt = next_fifo_cnt + 2'd1;
        end
      end
      default: next_rx_state = R_IDLE;
    endcase
    if (!rx_on) begin
      next_rx_state = R_IDLE;
    end
    if (!port_on) begin
      next_fifo_cnt = 2'd0;
      next_rd_ptr   = 1'b0;
      next_oerr     = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_m1    <= 1'b1;
      rx_m2    <= 1'b1;
      rx_m3    <= 1'b1;
      rx_f     <= 1'b1;
      rx_state <= R_IDLE;
      rx_os    <= 4'h0;
      rx_bits  <= 4'h0;
      rx_shift <= 9'h000;
      fifo[0]  <= '0;
      fifo[1]  <= '0;
      rd_ptr   <= 1'b0;
      fifo_cnt <= 2'd0;
      oerr     <= 1'b0;
    end else begin
      rx_m1    <= receive_data_pin;
      rx_m2    <= rx_m1;
      rx_m3    <= rx_m2;
      rx_f     <= next_rx_f;
      rx_state <= next_rx_state;
      rx_os    <= next_rx_os;
      rx_bits  <= next_rx_bits;
      rx_shift <= next_rx_shift;
      fifo     <= next_fifo;
      rd_ptr   <= next_rd_ptr;
      fifo_cnt <= next_fifo_cnt;
      oerr     <= next_oerr;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_queued;
    tx_write && sh_busy && tx_on && !hold_full && !tx_bit_end;
  endsequence
  sequence s_flag_late;
    tx_flag ##1 !tx_flag;
  endsequence
  a_pin_direction: assert property (rcs.port_en == !transmit_clock_pin_oe_n)
    else $error("pin direction not following port enable");
  a_direct_load: assert property (tx_write && !sh_busy && tx_on |=> sh_busy)
    else $error("idle write did not load shifter");
  a_hold_reload: assert property ($fell(sh_busy) && hold_full && tx_on |=> sh_busy)
    else $error("queued character not reloaded");
  a_start_bit: assert property ($rose(sh_busy) && !bdc.pol |=> !transmit_clock_pin_out)
    else $error("start bit not driven after load");
  a_idle_level: assert property (!sh_busy && tx_on |=> transmit_clock_pin_out == !$past(bdc.pol))
    else $error("idle level wrong for polarity");
  a_flag_timing: assert property (s_queued |=> s_flag_late)
    else $error("empty flag timing after write wrong");
  a_nine_bits: assert property ($rose(sh_busy) && $past(txs.nine) |-> sh_cnt == 4'hb)
    else $error("nine-bit frame length wrong");
  a_rx_pending: assert property (rx_push && rx_on && fifo_cnt == 2'd0 |=> rx_flag)
    else $error("completed character not pending");
  a_rx_gate: assert property (!rx_on |=> rx_state == R_IDLE)
    else $error("receiver active while disabled");
  a_port_off: assert property (!port_on |=> !sh_busy && fifo_cnt == 2'd0 && !oerr)
    else $error("port disable left state active");
endmodule
`default_nettype wire

// ==== verification/serial_far_end.sv ====
/*
  Far-end serial model: decodes frames seen on the transmit line and
  sends frames on the receive line. Assumes a resolved line, one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_far_end #(
  parameter int BIT = 4
) (
  input  wire logic aclk,
  input  wire logic line,
  input  wire logic inv,
  input  wire logic listen,
  input  wire logic nine,
  output logic      rx_pin
);
  logic [8:0] q[$];
  logic [8:0] c;
  int         i;
  // receive pin only ever driven here
  initial rx_pin = 1'b1;
  always begin
    @(posedge aclk);
    if (listen && (line ^ inv) === 1'b0) begin
      c = '0;
      repeat (BIT / 2) @(posedge aclk);
      for (i = 0; i < (nine ? 9 : 8); i++) begin
        repeat (BIT) @(posedge aclk);
        c[i] = line ^ inv;
      end
      repeat (BIT) @(posedge aclk);
      if ((line ^ inv) === 1'b1) q.push_back(c);
    end
  end
  task automatic send(input logic [7:0] d);
    int k;
    for (k = 0; k < 10; k++) begin
      rx_pin <= (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : d[k-1];
      repeat (BIT) @(posedge aclk);
    end
  endtask
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
/*
  Self-checking bench of the serial port: register bus master and a
  far-end model on the line. Assumes verilog/ on the include path.
*/
`timescale 1ns/1ps
`include "asp_defs.svh"
`default_nettype none
module testbench;
  localparam int BIT = 4;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic        rx_pin, pin_out, pin_oe_n, tx_irq, rx_irq, line, inv, listen, nine;
  int          failures, check_count, n;
  // Released pin floats to mark through a pull-up
  assign line = pin_oe_n ? 1'b1 : pin_out;
  always #4 aclk = ~aclk;
  async_serial_port #(.OVERSAMPLE(BIT)) uut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .receive_data_pin(rx_pin),
    .transmit_clock_pin_out(pin_out), .transmit_clock_pin_oe_n(pin_oe_n),
    .transmit_irq(tx_irq), .receive_irq(rx_irq));
  serial_far_end #(.BIT(BIT)) far (.aclk(aclk), .line(line), .inv(inv), .listen(listen),
    .nine(nine), .rx_pin(rx_pin));
  // ----------------------------------------------------------------------
  // Reporting and bus cycles
  // ----------------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic lim;
    if (n >= 400) begin
      failures++;
      $display("mismatch at %0t: wait limit", $time);
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do @(negedge aclk); while (awready !== 1'b1 && ++n < 400);
    lim();
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    n = 0;
    do @(negedge aclk); while (bvalid !== 1'b1 && ++n < 400);
    lim();
    resp = bresp;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do @(negedge aclk); while (arready !== 1'b1 && ++n < 400);
    lim();
    @(posedge aclk);
    arvalid <= 1'b0;
    n = 0;
    do @(negedge aclk); while (rvalid !== 1'b1 && ++n < 400);
    lim();
    rv   = rdata;
    resp = rresp;
    @(posedge aclk);
  endtask
  task automatic get_char(input logic [8:0] e);
    n = 0;
    do @(posedge aclk); while (far.q.size() == 0 && ++n < 400);
    lim();
    chk({23'h0, far.q.pop_front()}, {23'h0, e}, "char");
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs;
    rd(`ASP_BDC_OFS);
    chk(rv, 32'h0, "baud reset");
    rd(8'h40);
    chk({30'h0, resp}, 32'h2, "unmapped read");
    wr(8'h44, 8'hff);
    chk({30'h0, resp}, 32'h2, "unmapped write");
    wr(`ASP_RCS_OFS, 8'h80);
    chk({31'h0, pin_oe_n}, 32'h0, "pin driven");
  endtask
  task automatic t_tx;
    wr(`ASP_TXB_OFS, 8'h11);
    repeat (80) @(posedge aclk);
    chk(far.q.size(), 0, "frame while off");
    wr(`ASP_TXS_OFS, 8'h20);
    wr(`ASP_IEN_OFS, 8'h07);
    rd(`ASP_IEN_OFS);
    chk({31'h0, rv[4]}, 32'h1, "flag on enable");
    chk({31'h0, tx_irq}, 32'h1, "irq");
    wr(`ASP_TXB_OFS, 8'ha5);
    wr(`ASP_TXB_OFS, 8'h3c);
    rd(`ASP_TXS_OFS);
    chk({31'h0, rv[1]}, 32'h0, "shifter busy");
    rd(`ASP_IEN_OFS);
    chk({31'h0, rv[4]}, 32'h0, "flag queued");
    chk({31'h0, tx_irq}, 32'h0, "irq queued");
    get_char(9'h0a5);
    get_char(9'h03c);
    chk({31'h0, n <= 10 * BIT + 2}, 32'h1, "back to back");
    repeat (2 * BIT) @(posedge aclk);
    rd(`ASP_TXS_OFS);
    chk({31'h0, rv[1]}, 32'h1, "shifter empty");
    chk({31'h0, line}, 32'h1, "idle mark");
    wr(`ASP_IEN_OFS, 8'h03);
    rd(`ASP_IEN_OFS);
    chk({30'h0, rv[4], tx_irq}, 32'h2, "flag without enable");
  endtask
  task automatic t_nine;
    wr(`ASP_TXS_OFS, 8'h61);
    nine <= 1'b1;
    wr(`ASP_TXB_OFS, 8'h3c);
    get_char(9'h13c);
    nine <= 1'b0;
    wr(`ASP_TXS_OFS, 8'h30);
    rd(`ASP_IEN_OFS);
    chk({31'h0, rv[4]}, 32'h0, "flag in clocked mode");
    wr(`ASP_TXS_OFS, 8'h20);
  endtask
  task automatic t_pol;
    listen <= 1'b0;
    wr(`ASP_BDC_OFS, 8'h10);
    repeat (4) @(posedge aclk);
    chk({31'h0, line}, 32'h0, "inverted idle");
    inv    <= 1'b1;
    listen <= 1'b1;
    wr(`ASP_TXB_OFS, 8'h96);
    get_char(9'h096);
    listen <= 1'b0;
    wr(`ASP_BDC_OFS, 8'h00);
    inv    <= 1'b0;
    listen <= 1'b1;
  endtask
  task automatic t_rx;
    wr(`ASP_IEN_OFS, 8'h0b);
    far.send(8'h77);
    repeat (4 * BIT) @(posedge aclk);
    rd(`ASP_IEN_OFS);
    chk({31'h0, rv[5]}, 32'h0, "rx while off");
    wr(`ASP_RCS_OFS, 8'h90);
    far.send(8'h5a);
    far.send(8'hc3);
    repeat (4 * BIT) @(posedge aclk);
    rd(`ASP_IEN_OFS);
    chk({30'h0, rv[5], rx_irq}, 32'h3, "pending");
    rd(`ASP_RXB_OFS);
    chk(rv, 32'h5a, "first rx");
    rd(`ASP_RXB_OFS);
    chk(rv, 32'hc3, "second rx");
    rd(`ASP_IEN_OFS);
    chk({31'h0, rv[5]}, 32'h0, "drained");
    wr(`ASP_RCS_OFS, 8'h00);
    chk({31'h0, pin_oe_n}, 32'h1, "released");
  endtask
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, inv, nine} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb       = 4'hf;
    listen      = 1'b1;
    failures    = 0;
    check_count = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({31'h0, pin_oe_n}, 32'h1, "reset pin");
    t_regs();
    t_tx();
    t_nine();
    t_pol();
    t_rx();
    stop_test();
  end
endmodule
`default_nettype wire
